/* File: rtl/master_page_sync_config_regs.sv */
`include "master_sync_map.svh"
`default_nettype none

module master_page_sync_config_regs (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire master_sync_pkg::reg_addr_t reg_addr,
  input wire master_sync_pkg::reg_byte_t reg_wdata,
  output master_sync_pkg::reg_byte_t reg_rdata,
  output logic chan_b_powered_down,
  output logic sync_input_termination_off,
  output logic timing_ref_delay_enable,
  output master_sync_pkg::delay_code_t timing_ref_delay_code,
  output master_sync_pkg::delay_ps_t timing_ref_delay_ps,
  output logic timing_ref_delay_code_valid,
  output master_sync_pkg::amplitude_t lane_output_amplitude
);
  import master_sync_pkg::*;

  // Stored fields only; must-write bits hold no state and read back zero
  logic chan_b_powerdown;
  logic chan_b_powerdown_ctrl_enable;
  logic term_off;
  logic delay_en;
  logic [1:0] timing_ref_delay_code_high;
  logic [2:0] timing_ref_delay_code_low;
  amplitude_t amplitude;
  reg_byte_t rdata;
  logic pd_out;
  delay_ps_t delay_ps;
  logic code_valid;

  logic next_chan_b_powerdown;
  logic next_chan_b_powerdown_ctrl_enable;
  logic next_term_off;
  logic next_delay_en;
  logic [1:0] next_timing_ref_delay_code_high;
  logic [2:0] next_timing_ref_delay_code_low;
  amplitude_t next_amplitude;
  reg_byte_t next_rdata;
  logic next_pd_out;
  delay_ps_t next_delay_ps;
  logic next_code_valid;
  delay_code_t next_code;

  function automatic logic code_in_table(input delay_code_t code);
    code_in_table = (code >= `DELAY_CODE_LAST) && (code <= `DELAY_CODE_FIRST);
  endfunction

  // Nominal picoseconds; codes outside the table give zero
  function automatic delay_ps_t code_to_ps(input delay_code_t code);
    delay_code_t steps;
    steps = `DELAY_CODE_FIRST - code;
    if (code_in_table(code)) begin
      code_to_ps = `DELAY_FIRST_PS + delay_ps_t'(steps) * `DELAY_STEP_PS;
    end else begin
      code_to_ps = 9'h000;
    end
  endfunction

  always_comb begin
    next_chan_b_powerdown = chan_b_powerdown;
    next_chan_b_powerdown_ctrl_enable = chan_b_powerdown_ctrl_enable;
    next_term_off = term_off;
    next_delay_en = delay_en;
    next_timing_ref_delay_code_high = timing_ref_delay_code_high;
    next_timing_ref_delay_code_low = timing_ref_delay_code_low;
    next_amplitude = amplitude;
    next_rdata = rdata;
    if (reg_wr) begin
      case (reg_addr)
        `OFS_POWERDOWN: begin
          next_chan_b_powerdown = reg_wdata[`POS_CHAN_B_POWERDOWN];
        end
        `OFS_SYNC_PIN_CONFIG: begin
          // Bits 6 and 4 are write-only keys; dropped here
          next_chan_b_powerdown_ctrl_enable = reg_wdata[`POS_CHAN_B_POWERDOWN_CTRL_ENABLE];
          next_term_off = reg_wdata[`POS_SYNC_INPUT_TERMINATION_OFF];
        end
        `OFS_TIMING_REF_DELAY_HIGH: begin
          next_delay_en = reg_wdata[`POS_TIMING_REF_DELAY_ENABLE];
          next_timing_ref_delay_code_high =
            reg_wdata[`MSB_TIMING_REF_DELAY_CODE_HIGH:`LSB_TIMING_REF_DELAY_CODE_HIGH];
        end
        `OFS_TIMING_REF_DELAY_LOW: begin
          next_timing_ref_delay_code_low =
            reg_wdata[`MSB_TIMING_REF_DELAY_CODE_LOW:`LSB_TIMING_REF_DELAY_CODE_LOW];
        end
        `OFS_LANE_OUTPUT_AMPLITUDE_CTRL: begin
          next_amplitude = reg_wdata[`MSB_LANE_OUTPUT_AMPLITUDE:`LSB_LANE_OUTPUT_AMPLITUDE];
        end
        default: begin
        end
      endcase
    end
    if (reg_rd) begin
      next_rdata = 8'h00;
      case (reg_addr)
        `OFS_POWERDOWN: begin
          next_rdata[`POS_CHAN_B_POWERDOWN] = chan_b_powerdown;
        end
        `OFS_SYNC_PIN_CONFIG: begin
          next_rdata[`POS_CHAN_B_POWERDOWN_CTRL_ENABLE] = chan_b_powerdown_ctrl_enable;
          next_rdata[`POS_SYNC_INPUT_TERMINATION_OFF] = term_off;
        end
        `OFS_TIMING_REF_DELAY_HIGH: begin
          next_rdata[`POS_TIMING_REF_DELAY_ENABLE] = delay_en;
          next_rdata[`MSB_TIMING_REF_DELAY_CODE_HIGH:`LSB_TIMING_REF_DELAY_CODE_HIGH] =
            timing_ref_delay_code_high;
        end
        `OFS_TIMING_REF_DELAY_LOW: begin
          next_rdata[`MSB_TIMING_REF_DELAY_CODE_LOW:`LSB_TIMING_REF_DELAY_CODE_LOW] =
            timing_ref_delay_code_low;
        end
        `OFS_LANE_OUTPUT_AMPLITUDE_CTRL: begin
          next_rdata[`MSB_LANE_OUTPUT_AMPLITUDE:`LSB_LANE_OUTPUT_AMPLITUDE] = amplitude;
        end
        default: begin
        end
      endcase
    end
    // Outputs track the new register values so they settle with the write
    next_pd_out = next_chan_b_powerdown & next_chan_b_powerdown_ctrl_enable;
    next_code = {next_timing_ref_delay_code_high, next_timing_ref_delay_code_low};
    next_code_valid = code_in_table(next_code);
    next_delay_ps = next_delay_en ? code_to_ps(next_code) : 9'h000;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      chan_b_powerdown <= 1'b0;
      chan_b_powerdown_ctrl_enable <= 1'b0;
      term_off <= 1'b0;
      delay_en <= 1'b0;
      timing_ref_delay_code_high <= 2'h0;
      timing_ref_delay_code_low <= 3'h0;
      amplitude <= 3'h0;
      rdata <= `REG_RESET;
      pd_out <= 1'b0;
      delay_ps <= 9'h000;
      code_valid <= 1'b0;
    end else begin
      chan_b_powerdown <= next_chan_b_powerdown;
      chan_b_powerdown_ctrl_enable <= next_chan_b_powerdown_ctrl_enable;
      term_off <= next_term_off;
      delay_en <= next_delay_en;
      timing_ref_delay_code_high <= next_timing_ref_delay_code_high;
      timing_ref_delay_code_low <= next_timing_ref_delay_code_low;
      amplitude <= next_amplitude;
      rdata <= next_rdata;
      pd_out <= next_pd_out;
      delay_ps <= next_delay_ps;
      code_valid <= next_code_valid;
    end
  end

  assign reg_rdata = rdata;
  assign chan_b_powered_down = pd_out;
  assign sync_input_termination_off = term_off;
  assign timing_ref_delay_enable = delay_en;
  assign timing_ref_delay_code = {timing_ref_delay_code_high, timing_ref_delay_code_low};
  assign timing_ref_delay_ps = delay_ps;
  assign timing_ref_delay_code_valid = code_valid;
  assign lane_output_amplitude = amplitude;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  pd_gate_off_a: assert property (
    (reg_wr && reg_addr == `OFS_SYNC_PIN_CONFIG && !reg_wdata[1]) |=> !chan_b_powered_down)
    else $error("channel B powered down while control disabled");
  pd_gate_on_a: assert property (
    (reg_wr && reg_addr == `OFS_POWERDOWN && reg_wdata[1] && chan_b_powerdown_ctrl_enable) |=> chan_b_powered_down)
    else $error("channel B power-down not applied");
  term_write_a: assert property (
    (reg_wr && reg_addr == `OFS_SYNC_PIN_CONFIG) |=> sync_input_termination_off == $past(reg_wdata[0]))
    else $error("termination bit not taken");
  delay_off_a: assert property (
    !timing_ref_delay_enable |-> timing_ref_delay_ps == 9'h000)
    else $error("delay applied while disabled");
  code_high_a: assert property (
    (reg_wr && reg_addr == `OFS_TIMING_REF_DELAY_HIGH) |=> timing_ref_delay_code[4:3] == $past(reg_wdata[1:0]))
    else $error("delay code high bits wrong");
  code_low_a: assert property (
    (reg_wr && reg_addr == `OFS_TIMING_REF_DELAY_LOW) |=> timing_ref_delay_code[2:0] == $past(reg_wdata[7:5]))
    else $error("delay code low bits wrong");
  delay_first_a: assert property (
    (timing_ref_delay_enable && timing_ref_delay_code == 5'h08) |-> timing_ref_delay_ps == 9'h0af)
    else $error("code 8 not 175 ps");
  delay_last_a: assert property (
    (timing_ref_delay_enable && timing_ref_delay_code == 5'h03) |-> timing_ref_delay_ps == 9'h12c)
    else $error("code 3 not 300 ps");
  key_bits_zero_a: assert property (
    (reg_rd && reg_addr == `OFS_SYNC_PIN_CONFIG) |=> reg_rdata[7:2] == 6'h00)
    else $error("sync config key bits read back");

  pd_active_c: cover property (chan_b_powered_down);
  term_off_c: cover property (sync_input_termination_off);
  delay_max_c: cover property (timing_ref_delay_ps == 9'h12c);
  amp_set_c: cover property (lane_output_amplitude == 3'h7);
endmodule

`default_nettype wire

/* File: rtl/master_sync_map.svh */
`ifndef MASTER_SYNC_MAP_SVH
`define MASTER_SYNC_MAP_SVH

// Register offsets
`define OFS_POWERDOWN 8'h20
`define OFS_SYNC_PIN_CONFIG 8'h39
`define OFS_TIMING_REF_DELAY_HIGH 8'h3c
`define OFS_LANE_OUTPUT_AMPLITUDE_CTRL 8'h3d
`define OFS_TIMING_REF_DELAY_LOW 8'h5a

// Reset value shared by every register here
`define REG_RESET 8'h00

// Field positions
`define POS_CHAN_B_POWERDOWN 1
`define POS_CHAN_B_POWERDOWN_CTRL_ENABLE 1
`define POS_SYNC_INPUT_TERMINATION_OFF 0
`define POS_TIMING_REF_DELAY_ENABLE 6
`define MSB_TIMING_REF_DELAY_CODE_HIGH 1
`define LSB_TIMING_REF_DELAY_CODE_HIGH 0
`define MSB_TIMING_REF_DELAY_CODE_LOW 7
`define LSB_TIMING_REF_DELAY_CODE_LOW 5
`define MSB_LANE_OUTPUT_AMPLITUDE 2
`define LSB_LANE_OUTPUT_AMPLITUDE 0

// Nominal delay table: code 8 is the first step, each lower code adds a step
`define DELAY_CODE_FIRST 5'h08
`define DELAY_CODE_LAST 5'h03
`define DELAY_FIRST_PS 9'h0af
`define DELAY_STEP_PS 9'h019

`endif

/* File: rtl/master_sync_pkg.sv */
`default_nettype none

package master_sync_pkg;
  typedef logic [7:0] reg_addr_t;
  typedef logic [7:0] reg_byte_t;
  typedef logic [4:0] delay_code_t;
  typedef logic [8:0] delay_ps_t;
  typedef logic [2:0] amplitude_t;
endpackage

`default_nettype wire

/* File: verif/host_port_model.sv */
`default_nettype none

module host_port_model (
  input wire logic sys_clk,
  input wire master_sync_pkg::reg_byte_t reg_rdata,
  output logic reg_wr,
  output logic reg_rd,
  output master_sync_pkg::reg_addr_t reg_addr,
  output master_sync_pkg::reg_byte_t reg_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  import master_sync_pkg::*;

  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // Bus lines are inverted once released so a stale value never looks valid
  // Masking is done on a local copy so the data line changes only once per edge
  task automatic put(input reg_addr_t a, input reg_byte_t d);
    reg_byte_t w;
    w = d;
    if (a == 8'h39) w = (d & 8'h03) | 8'h50;
    if (a == 8'h3c) w = d & 8'h43;
    if (a == 8'h5a) w = d & 8'he0;
    if (a == 8'h3d) w = d & 8'h07;
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = w;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask

  task automatic get(input reg_addr_t a, output reg_byte_t d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    reg_addr = ~reg_addr;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask
endmodule

`default_nettype wire

/* File: verif/test_master_page_sync_config_regs.sv */
`default_nettype none

module test_master_page_sync_config_regs;
  timeunit 1ns;
  timeprecision 1ns;
  import master_sync_pkg::*;
  logic sys_clk, srst, reg_wr, reg_rd, chan_b_powered_down, sync_input_termination_off;
  logic timing_ref_delay_enable, timing_ref_delay_code_valid;
  reg_addr_t reg_addr;
  reg_byte_t reg_wdata, reg_rdata, rd_val;
  delay_code_t timing_ref_delay_code;
  delay_ps_t timing_ref_delay_ps;
  amplitude_t lane_output_amplitude;
  logic [7:0] seed = 8'h46;
  int n_errors = 0;
  int total_checks = 0;

  master_page_sync_config_regs master_page_sync_config_regs_inst (.sys_clk, .srst, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .chan_b_powered_down, .sync_input_termination_off,
    .timing_ref_delay_enable, .timing_ref_delay_code, .timing_ref_delay_ps, .timing_ref_delay_code_valid,
    .lane_output_amplitude);
  host_port_model host_port_model_inst (.sys_clk, .reg_rdata, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // Codes outside the table give no delay, matching the chosen reading
  function automatic delay_ps_t exp_ps(input logic en, input delay_code_t c);
    if (!en || c < 5'h03 || c > 5'h08) return 9'h000;
    return 9'h0af + 9'h019 * (9'h008 - {4'h0, c});
  endfunction

  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  initial begin
    #1ms;
    n_errors++;
    print_verdict;
  end

  initial begin
    srst = 1'b1;
    repeat (16) @(posedge sys_clk);
    @(negedge sys_clk);
    srst = 1'b0;
    for (int i = 0; i < 5; i++) begin
      host_port_model_inst.get(i == 0 ? 8'h20 : i == 1 ? 8'h39 : i == 2 ? 8'h3c : i == 3 ? 8'h3d : 8'h5a, rd_val);
      check(rd_val, 9'h000);
    end
    $display("Test reset values done");
    for (int i = 0; i < 8; i++) begin
      host_port_model_inst.put(8'h20, {6'h00, i[0], 1'b0});
      host_port_model_inst.put(8'h39, {6'h00, i[2:1]});
      @(negedge sys_clk);
      check(chan_b_powered_down, i[0] & i[2]);
      check(sync_input_termination_off, i[1]);
      host_port_model_inst.get(8'h39, rd_val);
      check(rd_val, {6'h00, i[2:1]});
      host_port_model_inst.get(8'h20, rd_val);
      check(rd_val, {6'h00, i[0], 1'b0});
    end
    $display("Test sync config done");
    for (int i = 0; i < 64; i++) begin
      host_port_model_inst.put(8'h3c, {1'b0, i[5], 4'h0, i[4:3]});
      host_port_model_inst.put(8'h5a, {i[2:0], 5'h00});
      @(negedge sys_clk);
      check(timing_ref_delay_enable, i[5]);
      check(timing_ref_delay_code, i[4:0]);
      check(timing_ref_delay_ps, exp_ps(i[5], i[4:0]));
      check(timing_ref_delay_code_valid, i[4:0] >= 3 && i[4:0] <= 8);
      host_port_model_inst.get(8'h3c, rd_val);
      check(rd_val, {1'b0, i[5], 4'h0, i[4:3]});
      host_port_model_inst.get(8'h5a, rd_val);
      check(rd_val, {i[2:0], 5'h00});
    end
    $display("Test delay code done");
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      host_port_model_inst.put(8'h3d, seed);
      @(negedge sys_clk);
      check(lane_output_amplitude, seed[2:0]);
      host_port_model_inst.get(8'h3d, rd_val);
      check(rd_val, {5'h00, seed[2:0]});
      if (!(seed inside {8'h20, 8'h39, 8'h3c, 8'h3d, 8'h5a})) begin
        host_port_model_inst.put(seed, ~seed);
        host_port_model_inst.get(seed, rd_val);
        check(rd_val, 9'h000);
        check(lane_output_amplitude, seed[2:0]);
      end
    end
    $display("Test amplitude and unmapped done");
    host_port_model_inst.put(8'h39, 8'h03);
    @(negedge sys_clk);
    srst = 1'b1;
    repeat (2) @(negedge sys_clk);
    srst = 1'b0;
    check(sync_input_termination_off, 1'b0);
    check(timing_ref_delay_enable, 1'b0);
    check(chan_b_powered_down, 1'b0);
    check(timing_ref_delay_ps, 9'h000);
    check(lane_output_amplitude, 3'h0);
    host_port_model_inst.get(8'h39, rd_val);
    check(rd_val, 9'h000);
    $display("Test mid-run reset done");
    print_verdict;
  end
endmodule

`default_nettype wire
